// ---- bench/sleg_core_test.sv ----
`timescale 1ns/100ps
`default_nettype none

// ==========================================================================
// Bench for the stack and address block
// ==========================================================================
module sleg_core_test;
    import sleg_pkg::*;
    typedef struct packed {
        logic        chk;
        logic [15:0] ea;
        logic        trap;
        logic        ill;
        logic        den;
        logic        ysp;
        logic [15:0] sp;
    } sleg_exp_t;
    logic        SYS_CLK, RST_N, REQ_READY, LIMIT_WE, EXEC_BOOT, EXEC_SECURE;
    logic        PUSH_STROBE, STACK_TRAP;
    logic [15:0] PTR_VAL, BASE_VAL, LIMIT_WDATA, PUSH_DATA, STACK_PTR, STACK_LIMIT, rd_word, d;
    logic [22:0] PC;
    logic [7:0]  STATUS_LOW_BYTE;
    sleg_req_t   REQ, r;
    sleg_seg_t   BOOT_SEG, SECURE_SEG;
    sleg_res_t   RES;
    sleg_exp_t   eq[$];
    sleg_exp_t   e;
    logic [15:0] dq[$];
    int          err_count, n_checks;

    sleg_core uut (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .REQ(REQ), .PTR_VAL(PTR_VAL), .BASE_VAL(BASE_VAL),
        .REQ_READY(REQ_READY), .LIMIT_WE(LIMIT_WE), .LIMIT_WDATA(LIMIT_WDATA), .PC(PC),
        .STATUS_LOW_BYTE(STATUS_LOW_BYTE), .EXEC_BOOT(EXEC_BOOT), .EXEC_SECURE(EXEC_SECURE),
        .BOOT_SEG(BOOT_SEG), .SECURE_SEG(SECURE_SEG), .RES(RES), .PUSH_STROBE(PUSH_STROBE),
        .PUSH_DATA(PUSH_DATA), .STACK_PTR(STACK_PTR), .STACK_LIMIT(STACK_LIMIT), .STACK_TRAP(STACK_TRAP));
    sleg_mem_model mem (.SYS_CLK(SYS_CLK), .RES(RES), .PUSH_STROBE(PUSH_STROBE), .PUSH_DATA(PUSH_DATA),
        .rd_word(rd_word));

    // ======================================================================
    // Helpers
    // ======================================================================
    // One comparison; four-state so an unknown never matches.
    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Verdict and end of run.
    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    function automatic sleg_req_t mk(sleg_op_t op, sleg_class_t c, sleg_mode_t m, logic [3:0] p, logic [15:0] l);
        mk = '0;
        mk.valid = 1'b1;
        mk.op = op;
        mk.cls = c;
        mk.mode = m;
        mk.ptr_idx = p;
        mk.literal = l;
        mk.sp_data = l;
        mk.offset = -16'sd4;
    endfunction

    function automatic sleg_exp_t ex(logic c, logic [15:0] a, logic t, logic i, logic dn, logic y, logic [15:0] s);
        ex = '{c, a, t, i, dn, y, s};
    endfunction

    // Presents a request, notes its answer and returns once the block is idle again.
    // Holding the request through a dead cycle checks that it is refused there.
    task automatic go(sleg_req_t q, sleg_exp_t x);
        REQ = q;
        eq.push_back(x);
        @(negedge SYS_CLK);
        while (REQ_READY !== 1'b1) @(negedge SYS_CLK);
    endtask

    task automatic limit(logic [15:0] v);
        LIMIT_WE = 1'b1;
        LIMIT_WDATA = v;
        @(negedge SYS_CLK);
        LIMIT_WE = 1'b0;
        // A spare cycle keeps a stack read clear of the limit write.
        @(negedge SYS_CLK);
    endtask

    // ======================================================================
    // Clock, watchdog and monitor
    // ======================================================================
    // Free-running 50 MHz clock.
    initial begin
        SYS_CLK = 1'b0;
        forever #10 SYS_CLK = ~SYS_CLK;
    end

    // The tests need well under 200 cycles; a hang ends the run as a failure.
    initial begin
        #100000;
        err_count++;
        $display("watchdog expired");
        summarize();
    end

    // Takes the oldest note whenever an answer or a pushed word appears.
    always @(negedge SYS_CLK) begin
        if (RST_N === 1'b1 && RES.valid === 1'b1) begin
            if (eq.size() == 0) check("unexpected answer", 1, 0);
            else begin
                e = eq.pop_front();
                check("stack pointer", STACK_PTR, e.sp);
                check("stack trap", STACK_TRAP, e.trap);
                if (e.chk) check("flags", {RES.illegal, RES.denied, RES.y_space},
                                 {e.ill, e.den, e.ysp});
                if (e.chk && !e.ill) check("address", RES.ea, e.ea);
            end
        end
        if (RST_N === 1'b1 && PUSH_STROBE === 1'b1) begin
            if (dq.size() == 0) check("unexpected push", 1, 0);
            else check("pushed word", PUSH_DATA, dq.pop_front());
        end
    end

    // ======================================================================
    // Tests
    // ======================================================================
    // Reset, stack rules, calls, address modes and RAM protection in turn.
    initial begin
        {REQ, PTR_VAL, BASE_VAL, LIMIT_WE, LIMIT_WDATA, PC, STATUS_LOW_BYTE} = '0;
        {EXEC_BOOT, EXEC_SECURE, BOOT_SEG, SECURE_SEG, err_count, n_checks} = '0;
        RST_N = 1'b0;
        void'($urandom(61));
        repeat (2) @(posedge SYS_CLK);
        @(negedge SYS_CLK);
        RST_N = 1'b1;
        check("reset pointer", {REQ_READY, STACK_PTR}, {1'b1, 16'h0800});
        limit(16'h0803);
        check("limit", STACK_LIMIT, 16'h0802);
        $display("test reset and limit done");
        // Back-to-back pushes: the one at the limit passes, the next traps.
        for (int i = 0; i < 3; i++) begin
            d = 16'($urandom);
            dq.push_back(d);
            go(mk(OP_PUSH, C_MCU, M_IND, 4'hf, d),
               ex(1, 16'h0800 + 16'(2 * i), i == 2, 0, 0, 0, 16'h0802 + 16'(2 * i)));
        end
        go(mk(OP_ACCESS, C_MCU, M_IND, 4'hf, 16'h0), ex(1, 16'h0806, 1, 0, 0, 0, 16'h0806));
        REQ.valid = 1'b0;
        limit(16'h1ffe);
        go(mk(OP_POP, C_MCU, M_IND, 4'hf, 16'h0), ex(1, 16'h0804, 0, 0, 0, 0, 16'h0804));
        check("popped word", rd_word, d);
        go(mk(OP_SP_WRITE, C_MCU, M_IND, 4'hf, 16'h0801), ex(0, 0, 0, 0, 0, 0, 16'h0800));
        go(mk(OP_POP, C_MCU, M_IND, 4'hf, 16'h0), ex(1, 16'h07fe, 1, 0, 0, 0, 16'h07fe));
        go(mk(OP_SP_WRITE, C_MCU, M_IND, 4'hf, 16'h0900), ex(0, 0, 0, 0, 0, 0, 16'h0900));
        $display("test stack done");
        // Call then exception push, each as two words.
        PC = 23'($urandom);
        dq.push_back(PC[15:0]);
        dq.push_back({9'h0, PC[22:16]});
        eq.push_back(ex(0, 0, 0, 0, 0, 0, 16'h0902));
        go(mk(OP_CALL, C_MCU, M_IND, 4'hf, 16'h0), ex(0, 0, 0, 0, 0, 0, 16'h0904));
        PC = 23'($urandom);
        STATUS_LOW_BYTE = 8'($urandom);
        dq.push_back(PC[15:0]);
        dq.push_back({STATUS_LOW_BYTE, 1'b0, PC[22:16]});
        eq.push_back(ex(0, 0, 0, 0, 0, 0, 16'h0906));
        go(mk(OP_EXC, C_MCU, M_IND, 4'hf, 16'h0), ex(0, 0, 0, 0, 0, 0, 16'h0908));
        $display("test call done");
        // Address modes; MAC pointers stay inside their own space.
        PTR_VAL = 16'h1000;
        BASE_VAL = 16'($urandom) & 16'h07fe;
        go(mk(OP_ACCESS, C_MCU, M_IND, 4'h3, 16'h0), ex(1, 16'h1000, 0, 0, 0, 0, 16'h0908));
        go(mk(OP_ACCESS, C_MCU, M_PRE, 4'h3, 16'h0), ex(1, 16'h0ffc, 0, 0, 0, 0, 16'h0908));
        go(mk(OP_ACCESS, C_MCU, M_POST, 4'h3, 16'h0), ex(1, 16'h1000, 0, 0, 0, 0, 16'h0908));
        check("post write-back", {RES.wb, RES.wb_val}, {1'b1, 16'h0ffc});
        r = mk(OP_ACCESS, C_MOVE, M_INDEX, 4'h3, 16'h0);
        r.base_idx = 4'h2;
        go(r, ex(1, 16'h1000 + BASE_VAL, 0, 0, 0, 0, 16'h0908));
        r = mk(OP_ACCESS, C_FILE, M_FILE, 4'h3, 16'h9abc);
        {r.faddr, r.dest_default_working_register, r.base_idx} = {13'h1abc, 1'b1, 4'h5};
        go(r, ex(1, 16'h1abc, 0, 0, 0, 0, 16'h0908));
        check("file destination", RES.dest_idx, 4'h0);
        r.cls = C_MOVE;
        go(r, ex(1, 16'h9abc, 0, 0, 0, 0, 16'h0908));
        check("move destination", RES.dest_idx, 4'h5);
        go(mk(OP_ACCESS, C_MAC, M_IND, 4'h8, 16'h0), ex(1, 16'h1000, 0, 0, 0, 0, 16'h0908));
        go(mk(OP_ACCESS, C_MAC, M_IND, 4'ha, 16'h0), ex(1, 16'h1000, 0, 0, 0, 1, 16'h0908));
        go(mk(OP_ACCESS, C_MAC, M_INDEX, 4'h8, 16'h0), ex(1, 0, 0, 1, 0, 0, 16'h0908));
        go(mk(OP_ACCESS, C_MAC, M_PRE, 4'h9, 16'h0), ex(1, 0, 0, 1, 0, 0, 16'h0908));
        $display("test modes done");
        // Each protected segment is open only to its own code origin.
        BOOT_SEG = '{1'b1, 16'h1000, 16'h10ff};
        SECURE_SEG = '{1'b1, 16'h1100, 16'h11ff};
        for (int i = 0; i < 4; i++) begin
            PTR_VAL = i[1] ? 16'h1100 : 16'h1000;
            EXEC_BOOT = !i[1] && i[0];
            EXEC_SECURE = i[1] && i[0];
            go(mk(OP_ACCESS, C_MCU, M_IND, 4'h3, 16'h0), ex(1, PTR_VAL, 0, 0, !i[0], 0, 16'h0908));
        end
        REQ.valid = 1'b0;
        repeat (3) @(negedge SYS_CLK);
        $display("test protection done");
        check("notes left", eq.size() + dq.size(), 0);
        summarize();
    end
endmodule
`default_nettype wire

// ---- bench/sleg_mem_model.sv ----
`timescale 1ns/100ps
`default_nettype none

// ==========================================================================
// Data memory seen from the far side of the block
// ==========================================================================
module sleg_mem_model
    import sleg_pkg::*;
(
    // Clock
    input  wire logic        SYS_CLK,
    // Core answer
    input  wire sleg_res_t   RES,
    input  wire logic        PUSH_STROBE,
    input  wire logic [15:0] PUSH_DATA,
    // Word at the answered address
    output logic [15:0]      rd_word
);
    logic [15:0] mem [0:255];

    // Pushed words land at the answered address, so the stack fills upward.
    always_ff @(posedge SYS_CLK) begin
        if (PUSH_STROBE && RES.valid) begin
            mem[RES.ea[8:1]] <= PUSH_DATA;
        end
    end

    // Only a small window is kept; higher addresses alias onto it, and the words these tests push never share a slot.
    assign rd_word = mem[RES.ea[8:1]];
endmodule
`default_nettype wire

// ---- src/sleg_core.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "sleg_map.svh"

module sleg_core
    import sleg_pkg::*;
#(
    parameter logic [15:0] SP_RESET = `SLEG_SP_RESET,
    parameter logic [15:0] SP_FLOOR = `SLEG_SP_FLOOR
)
(
    // Clock and reset
    input  wire logic        SYS_CLK,
    input  wire logic        RST_N,
    // Decoder request and register file operands
    input  wire sleg_req_t   REQ,
    input  wire logic [15:0] PTR_VAL,
    input  wire logic [15:0] BASE_VAL,
    output logic             REQ_READY,
    // Stack limit write port
    input  wire logic        LIMIT_WE,
    input  wire logic [15:0] LIMIT_WDATA,
    // Counter and status for pushes
    input  wire logic [22:0] PC,
    input  wire logic [7:0]  STATUS_LOW_BYTE,
    // Execution origin and protected segments
    input  wire logic        EXEC_BOOT,
    input  wire logic        EXEC_SECURE,
    input  wire sleg_seg_t   BOOT_SEG,
    input  wire sleg_seg_t   SECURE_SEG,
    // Answer to data memory
    output sleg_res_t        RES,
    output logic             PUSH_STROBE,
    output logic [15:0]      PUSH_DATA,
    // Stack state and trap
    output logic [15:0]      STACK_PTR,
    output logic [15:0]      STACK_LIMIT,
    output logic             STACK_TRAP
);

    // ======================================================================
    // Parameter checks
    // ======================================================================
    if (SP_RESET[0] != 1'b0) begin : g_bad_reset
        $error("Stack pointer reset value must be word aligned.");
    end
    if (SP_FLOOR[0] != 1'b0) begin : g_bad_floor
        $error("Stack floor must be word aligned.");
    end

    // ======================================================================
    // Sequencer for two-word pushes
    // ======================================================================
    typedef enum logic {S_IDLE, S_HIGH} sleg_state_t;

    sleg_state_t state;
    logic [15:0] high_word;
    logic        take;
    logic        hi_push;

    // A request is taken only while the sequencer is idle.
    assign take    = REQ.valid && (state == S_IDLE);
    assign hi_push = (state == S_HIGH);

    // Calls and exceptions push the low word now and the high word next.
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            state <= S_IDLE;
        end else begin
            case (state)
                S_IDLE: begin
                    if (take && ((REQ.op == OP_CALL) || (REQ.op == OP_EXC))) begin
                        state <= S_HIGH;
                    end
                end
                S_HIGH: state <= S_IDLE;
                default: state <= S_IDLE;
            endcase
        end
    end

    // High word: cleared top bits for a call, status byte for an exception.
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            high_word <= 16'h0000;
        end else if (take && (REQ.op == OP_CALL)) begin
            high_word <= {9'h000, PC[22:16]};
        end else if (take && (REQ.op == OP_EXC)) begin
            high_word <= {STATUS_LOW_BYTE, 1'b0, PC[22:16]};
        end
    end

    // Ready is low during the cycle that pushes the high word.
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            REQ_READY <= 1'b1;
        end else begin
            REQ_READY <= !(take && ((REQ.op == OP_CALL) || (REQ.op == OP_EXC)));
        end
    end

    // ======================================================================
    // Address generation
    // ======================================================================
    logic [15:0] sp;
    logic [15:0] stack_limit;
    logic [15:0] ptr_eff;
    logic [15:0] calc_ea;
    logic [15:0] calc_next;
    logic        calc_wb;
    logic        calc_legal;
    logic        guard_denied;
    logic        is_push;
    logic        is_pop;
    logic        uses_sp;
    logic [15:0] used_ea;

    // The stack pointer is kept here, so the pointer operand bypasses it.
    assign ptr_eff = (REQ.ptr_idx == `SLEG_SP_IDX) ? sp : PTR_VAL;

    sleg_ea_calc u_calc (
        .req      (REQ),
        .ptr      (ptr_eff),
        .base     (BASE_VAL),
        .ea       (calc_ea),
        .next_ptr (calc_next),
        .wb       (calc_wb),
        .legal    (calc_legal)
    );

    assign is_push = hi_push || (take && ((REQ.op == OP_PUSH) || (REQ.op == OP_CALL) ||
                                          (REQ.op == OP_EXC)));
    assign is_pop  = take && (REQ.op == OP_POP);

    // Push uses the free word; pop steps back first.
    assign used_ea = is_pop ? (sp - `SLEG_WORD_STEP) : (is_push ? sp : calc_ea);

    // Any address formed through the stack pointer is checked.
    assign uses_sp = is_push || is_pop ||
                     (take && (REQ.op == OP_ACCESS) && (REQ.ptr_idx == `SLEG_SP_IDX) &&
                      (REQ.mode != M_DIRECT) && (REQ.mode != M_LIT) && (REQ.mode != M_FILE));

    sleg_ram_guard u_guard (
        .ea          (used_ea),
        .from_boot   (EXEC_BOOT),
        .from_secure (EXEC_SECURE),
        .boot_seg    (BOOT_SEG),
        .secure_seg  (SECURE_SEG),
        .denied      (guard_denied)
    );

    // ======================================================================
    // Stack pointer and limit
    // ======================================================================
    // Stack pointer always holds the next free word, word aligned.
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            sp <= SP_RESET;
        end else if (is_push) begin
            sp <= sp + `SLEG_WORD_STEP;
        end else if (is_pop) begin
            sp <= sp - `SLEG_WORD_STEP;
        end else if (take && (REQ.op == OP_SP_WRITE)) begin
            sp <= {REQ.sp_data[15:1], 1'b0};
        end else if (take && (REQ.op == OP_ACCESS) && calc_wb && calc_legal &&
                     (REQ.ptr_idx == `SLEG_SP_IDX)) begin
            sp <= {calc_next[15:1], 1'b0};
        end
    end

    // The limit has no reset on purpose; it holds garbage until written.
    // A write lands at the edge that ends its cycle, so only a stack read in
    // that same cycle sees the old limit.
    always_ff @(posedge SYS_CLK) begin
        if (LIMIT_WE) begin
            stack_limit <= {LIMIT_WDATA[15:1], 1'b0};
        end
    end

    // ======================================================================
    // Trap and answer registers
    // ======================================================================
    // Overflow above the limit and underflow below the floor share one
    // trap line; equality with the limit is still legal.
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            STACK_TRAP <= 1'b0;
        end else begin
            STACK_TRAP <= uses_sp && ((used_ea > stack_limit) || (used_ea < SP_FLOOR));
        end
    end

    // Push data goes out with its strobe.
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            PUSH_STROBE <= 1'b0;
            PUSH_DATA   <= 16'h0000;
        end else begin
            PUSH_STROBE <= is_push;
            if (hi_push) begin
                PUSH_DATA <= high_word;
            end else if (take && ((REQ.op == OP_CALL) || (REQ.op == OP_EXC))) begin
                PUSH_DATA <= PC[15:0];
            end else if (take && (REQ.op == OP_PUSH)) begin
                PUSH_DATA <= REQ.literal;
            end
        end
    end

    // The registered answer to data memory.
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            RES <= '0;
        end else begin
            RES.valid   <= take || hi_push;
            RES.ea      <= used_ea;
            RES.wb      <= take && (REQ.op == OP_ACCESS) && calc_wb && calc_legal;
            RES.wb_val  <= calc_next;
            // One shared offset field serves both move operands.
            RES.illegal <= take && (REQ.op == OP_ACCESS) && !calc_legal;
            RES.denied  <= (take || hi_push) && guard_denied;
            // The first two MAC pointers read X space, the other two Y.
            RES.y_space <= take && (REQ.cls == C_MAC) && REQ.ptr_idx[1];
            // File results go to the default register when the request asks for it, unless it is a multiply.
            if (take && (REQ.cls == C_FILE) && REQ.dest_default_working_register && !REQ.is_mul) begin
                RES.dest_idx <= `SLEG_DREG_IDX;
            end else begin
                RES.dest_idx <= REQ.base_idx;
            end
        end
    end

    assign STACK_PTR   = sp;
    assign STACK_LIMIT = stack_limit;

    // ======================================================================
    // Assertions
    // ======================================================================
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RST_N);

    property p_push_step;
        take && (REQ.op == OP_PUSH) |=> (STACK_PTR == $past(STACK_PTR) + 16'h0002) &&
                                        (RES.ea == $past(STACK_PTR));
    endproperty
    a_push_step: assert property (p_push_step) else $error("Push did not post-increment.");

    property p_pop_step;
        take && (REQ.op == OP_POP) |=> (RES.ea == $past(STACK_PTR) - 16'h0002) &&
                                       (STACK_PTR == RES.ea);
    endproperty
    a_pop_step: assert property (p_pop_step) else $error("Pop did not pre-decrement.");

    property p_free_word;
        PUSH_STROBE |-> RES.ea + 16'h0002 == STACK_PTR;
    endproperty
    a_free_word: assert property (p_free_word) else $error("Stack pointer not on free word.");

    property p_call_msb;
        take && (REQ.op == OP_CALL) |=> PUSH_STROBE && !REQ_READY ##1 PUSH_STROBE && !PUSH_DATA[15];
    endproperty
    a_call_msb: assert property (p_call_msb) else $error("Call high word not cleared.");

    property p_exc_status;
        take && (REQ.op == OP_EXC) |-> ##2 PUSH_DATA[15:8] == $past(STATUS_LOW_BYTE, 2);
    endproperty
    a_exc_status: assert property (p_exc_status) else $error("Status byte missing.");

    property p_limit_write;
        LIMIT_WE |=> STACK_LIMIT == {$past(LIMIT_WDATA[15:1]), 1'b0};
    endproperty
    a_limit_write: assert property (p_limit_write) else $error("Limit not aligned.");

    property p_over_limit;
        take && (REQ.op == OP_PUSH) && (STACK_PTR >= SP_FLOOR) |=>
            STACK_TRAP == ($past(STACK_PTR) > $past(STACK_LIMIT));
    endproperty
    a_over_limit: assert property (p_over_limit) else $error("Limit trap wrong.");

    property p_underflow;
        take && (REQ.op == OP_POP) && (STACK_PTR < SP_FLOOR + 16'h0002) |=> STACK_TRAP;
    endproperty
    a_underflow: assert property (p_underflow) else $error("Underflow trap missing.");

    property p_mac_space;
        take && (REQ.cls == C_MAC) && (REQ.op == OP_ACCESS) |=> RES.y_space == $past(REQ.ptr_idx[1]);
    endproperty
    a_mac_space: assert property (p_mac_space) else $error("MAC space wrong.");

    property p_near_file;
        take && (REQ.cls == C_FILE) && (REQ.op == OP_ACCESS) && (REQ.mode == M_FILE) |=> RES.ea[15:13] == 3'h0;
    endproperty
    a_near_file: assert property (p_near_file) else $error("File address not near.");

    property p_default_working_register_dest;
        take && (REQ.cls == C_FILE) && REQ.dest_default_working_register && !REQ.is_mul |=> RES.dest_idx == `SLEG_DREG_IDX;
    endproperty
    a_default_working_register_dest: assert property (p_default_working_register_dest) else $error("File result misplaced.");

    property p_mac_modes;
        take && (REQ.cls == C_MAC) && (REQ.op == OP_ACCESS) && (REQ.mode == M_PRE) |=> RES.illegal;
    endproperty
    a_mac_modes: assert property (p_mac_modes) else $error("MAC pre-modify accepted.");

    // A trap must come from an address formed through the stack pointer.
    property p_single_trap;
        STACK_TRAP |-> $past(uses_sp);
    endproperty
    a_single_trap: assert property (p_single_trap) else $error("Trap without stack address.");

endmodule
`default_nettype wire

// ---- src/sleg_ea_calc.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "sleg_map.svh"

module sleg_ea_calc
    import sleg_pkg::*;
(
    // Request and operand values
    input  wire sleg_req_t   req,
    input  wire logic [15:0] ptr,
    input  wire logic [15:0] base,
    // Computed address
    output logic [15:0]      ea,
    output logic [15:0]      next_ptr,
    output logic             wb,
    output logic             legal
);

    // ======================================================================
    // Mode checks
    // ======================================================================
    // MAC post-modification steps are 2, 4 or 6 in either direction.
    function automatic logic mac_step_ok(input logic signed [15:0] s);
        mac_step_ok = (s == 16'sh0002) || (s == 16'sh0004) || (s == 16'sh0006) ||
                      (s == -16'sh0002) || (s == -16'sh0004) || (s == -16'sh0006);
    endfunction

    // Effective address per mode; pre and post modify write the pointer back.
    always_comb begin
        ea       = ptr;
        next_ptr = ptr;
        wb       = 1'b0;
        case (req.mode)
            M_FILE: begin
                // Only moves see the whole data space; the rest stay near.
                if (req.cls == C_MOVE) begin
                    ea = req.literal;
                end else begin
                    ea = {3'h0, req.faddr};
                end
            end
            M_POST: begin
                next_ptr = ptr + req.offset;
                wb       = 1'b1;
            end
            M_PRE: begin
                ea       = ptr + req.offset;
                next_ptr = ptr + req.offset;
                wb       = 1'b1;
            end
            M_INDEX: ea = ptr + base;
            M_LITOFF: ea = ptr + req.literal;
            default: ea = ptr;
        endcase
    end

    // Each instruction class only accepts its own subset of modes.
    always_comb begin
        legal = 1'b0;
        case (req.cls)
            C_FILE: legal = (req.mode == M_FILE) || (req.mode == M_DIRECT);
            C_MCU: begin
                // Literals for MCU operations are at most ten bits wide.
                legal = (req.mode == M_DIRECT) || (req.mode == M_IND) ||
                        (req.mode == M_POST) || (req.mode == M_PRE) ||
                        ((req.mode == M_LIT) && (req.literal[15:10] == 6'h00));
            end
            C_MOVE: legal = 1'b1;
            C_MAC: begin
                legal = (req.ptr_idx >= `SLEG_MAC_LO) && (req.ptr_idx <= `SLEG_MAC_HI) &&
                        ((req.mode == M_IND) ||
                         ((req.mode == M_POST) && mac_step_ok(req.offset)) ||
                         ((req.mode == M_INDEX) && ((req.ptr_idx == `SLEG_MAC_IDX_X) ||
                                                    (req.ptr_idx == `SLEG_MAC_IDX_Y))));
            end
            default: legal = 1'b0;
        endcase
    end

endmodule
`default_nettype wire

// ---- src/sleg_map.svh ----
`ifndef SLEG_MAP_SVH
`define SLEG_MAP_SVH

// ==========================================================================
// Stack and addressing constants
// ==========================================================================
// Lowest legal stack address; below it lies the special function space.
`define SLEG_SP_FLOOR   16'h0800
// Stack pointer value after reset.
`define SLEG_SP_RESET   16'h0800
// One stack word in bytes.
`define SLEG_WORD_STEP  16'h0002
// Register index of the stack pointer and of the default working register.
`define SLEG_SP_IDX     4'hf
`define SLEG_DREG_IDX   4'h0
// Prefetch pointer range for MAC-class reads.
`define SLEG_MAC_LO     4'h8
`define SLEG_MAC_HI     4'hb
// MAC pointers that may use the register-indexed mode.
`define SLEG_MAC_IDX_X  4'h9
`define SLEG_MAC_IDX_Y  4'hb
// Width of the near direct address field.
`define SLEG_NEAR_W     13

`endif

// ---- src/sleg_pkg.sv ----
package sleg_pkg;

    // ======================================================================
    // Request and result types
    // ======================================================================
    // Address-generation modes.
    typedef enum logic [2:0] {
        M_FILE, M_DIRECT, M_IND, M_POST, M_PRE, M_INDEX, M_LITOFF, M_LIT
    } sleg_mode_t;

    // Instruction classes.
    typedef enum logic [1:0] {
        C_FILE, C_MCU, C_MOVE, C_MAC
    } sleg_class_t;

    // Stack-related operations.
    typedef enum logic [2:0] {
        OP_ACCESS, OP_PUSH, OP_POP, OP_CALL, OP_EXC, OP_SP_WRITE
    } sleg_op_t;

    // One request from the instruction decoder.
    typedef struct packed {
        logic               valid;
        sleg_op_t           op;
        sleg_class_t        cls;
        sleg_mode_t         mode;
        logic [3:0]         ptr_idx;
        logic [3:0]         base_idx;
        logic signed [15:0] offset;
        logic [15:0]        literal;
        logic [12:0]        faddr;
        logic               dest_default_working_register;
        logic               is_mul;
        logic [15:0]        sp_data;
    } sleg_req_t;

    // One registered answer to the data memory side.
    typedef struct packed {
        logic        valid;
        logic [15:0] ea;
        logic        wb;
        logic [15:0] wb_val;
        logic        y_space;
        logic [3:0]  dest_idx;
        logic        illegal;
        logic        denied;
    } sleg_res_t;

    // One protected RAM segment.
    typedef struct packed {
        logic        en;
        logic [15:0] lo;
        logic [15:0] hi;
    } sleg_seg_t;

endpackage

// ---- src/sleg_ram_guard.sv ----
`timescale 1ns/100ps
`default_nettype none

module sleg_ram_guard
    import sleg_pkg::*;
(
    // Address and execution origin
    input  wire logic [15:0] ea,
    input  wire logic        from_boot,
    input  wire logic        from_secure,
    // Protected segments
    input  wire sleg_seg_t   boot_seg,
    input  wire sleg_seg_t   secure_seg,
    // Verdict
    output logic             denied
);

    // ======================================================================
    // Segment check
    // ======================================================================
    function automatic logic hits(input sleg_seg_t s, input logic [15:0] a);
        hits = s.en && (a >= s.lo) && (a <= s.hi);
    endfunction

    // A segment is open only to code running from its own flash segment.
    always_comb begin
        denied = (hits(boot_seg, ea) && !from_boot) ||
                 (hits(secure_seg, ea) && !from_secure);
    end

endmodule
`default_nettype wire
